// File: include/cstx_defs.svh
// constants for the skip, table-read and exclusive-or execution unit
`ifndef CSTX_DEFS_SVH
`define CSTX_DEFS_SVH
`define CSTX_PC_W        14
`define CSTX_PAGE_W      6
`define CSTX_PTR_W       8
`define CSTX_LAST_PAGE   6'h3F
`define CSTX_ZERO_BYTE   8'h00
`define CSTX_NIB_LO      3:0
`define CSTX_NIB_HI      7:4
`define CSTX_WORD_LO     7:0
`define CSTX_WORD_HI     15:8
`define CSTX_PC_PAGE     13:8
`define CSTX_ACC_RST     8'h00
`define CSTX_TABLE_HIGH_LATCH_RST    8'h00
`endif

// File: include/cstx_pkg.sv
// types for the skip, table-read and exclusive-or execution unit
package cstx_pkg;
    typedef enum logic [3:0] {
        CSTX_NOP,
        CSTX_SWAP_ACC,
        CSTX_SKIP_ZERO,
        CSTX_COPY_SKIP,
        CSTX_BIT_SKIP,
        CSTX_TBL_CUR,
        CSTX_TBL_LAST,
        CSTX_XOR_ACC,
        CSTX_XOR_MEM,
        CSTX_XOR_IMM
    } cstx_op_t;

    typedef struct packed {
        logic        valid;
        cstx_op_t    op;
        logic [2:0]  bit_sel;
        logic [7:0]  imm;
        logic [7:0]  mem_data;
        logic [13:0] pc;
        logic [7:0]  ptr;
    } cstx_req_t;

    typedef enum logic [1:0] {
        CSTX_IDLE,
        CSTX_TBL_WAIT,
        CSTX_DUMMY
    } cstx_state_t;

    typedef struct packed {
        cstx_state_t state;
        logic [7:0]  acc;
        logic [7:0]  tbl_high;
        logic        zero_flag;
        logic        mem_we;
        logic [7:0]  mem_wdata;
        logic        skip;
        logic        busy;
        logic        rom_re;
        logic [13:0] rom_addr;
        logic        done;
    } cstx_regs_t;
endpackage : cstx_pkg

// File: design/cstx_xor_zero.sv
// bitwise exclusive-or with a zero test of the result
`timescale 1ns/10ps
module cstx_xor_zero (
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    output logic      [7:0] y,
    output logic            is_zero
);
    assign y       = a ^ b;
    assign is_zero = ~|y;
endmodule : cstx_xor_zero

// File: design/cstx_exec.sv
// execution unit for swap, skip, table-read and exclusive-or instructions
`timescale 1ns/10ps
`include "cstx_defs.svh"
module cstx_exec
    import cstx_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RESET,
    // decoded instruction with operand
    input  wire cstx_req_t   REQ,
    // program memory read
    input  wire logic [15:0] ROM_DATA,
    output logic             ROM_RE,
    output logic [13:0]      ROM_ADDR,
    // data memory write-back
    output logic             MEM_WE,
    output logic [7:0]       MEM_WDATA,
    // core state
    output logic [7:0]       ACC,
    output logic [7:0]       TBL_HIGH,
    output logic             ZERO_FLAG,
    // sequencing
    output logic             SKIP,
    output logic             BUSY,
    output logic             DONE
);
    cstx_regs_t r;
    cstx_regs_t next_r;
    logic [7:0] xor_b;
    logic [7:0] xor_y;
    logic       xor_z;
    logic       byte_zero;
    logic       bit_clear;

    default clocking cb_sys @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);

    // one shared xor: immediate form takes the constant, others the byte
    assign xor_b = (REQ.op == CSTX_XOR_IMM) ? REQ.imm : REQ.mem_data;

    cstx_xor_zero u_xor (
        .a       (r.acc),
        .b       (xor_b),
        .y       (xor_y),
        .is_zero (xor_z)
    );

    assign byte_zero = (REQ.mem_data == `CSTX_ZERO_BYTE);
    assign bit_clear = ~REQ.mem_data[REQ.bit_sel];

    always_comb begin
        next_r        = r;
        next_r.mem_we = 1'b0;
        next_r.skip   = 1'b0;
        next_r.done   = 1'b0;
        next_r.rom_re = 1'b0;
        case (r.state)
            CSTX_IDLE: begin
                next_r.busy = 1'b0;
                if (REQ.valid) begin
                    case (REQ.op)
                        CSTX_SWAP_ACC: begin
                            next_r.acc = {REQ.mem_data[`CSTX_NIB_LO],
                                          REQ.mem_data[`CSTX_NIB_HI]};
                            next_r.done = 1'b1;
                        end
                        CSTX_SKIP_ZERO: begin
                            if (byte_zero) begin
                                next_r.skip  = 1'b1;
                                next_r.busy  = 1'b1;
                                next_r.state = CSTX_DUMMY;
                            end else begin
                                next_r.done = 1'b1;
                            end
                        end
                        CSTX_COPY_SKIP: begin
                            next_r.acc = REQ.mem_data;
                            if (byte_zero) begin
                                next_r.skip  = 1'b1;
                                next_r.busy  = 1'b1;
                                next_r.state = CSTX_DUMMY;
                            end else begin
                                next_r.done = 1'b1;
                            end
                        end
                        CSTX_BIT_SKIP: begin
                            if (bit_clear) begin
                                next_r.skip  = 1'b1;
                                next_r.busy  = 1'b1;
                                next_r.state = CSTX_DUMMY;
                            end else begin
                                next_r.done = 1'b1;
                            end
                        end
                        CSTX_TBL_CUR: begin
                            next_r.rom_re   = 1'b1;
                            next_r.rom_addr = {REQ.pc[`CSTX_PC_PAGE],
                                               REQ.ptr};
                            next_r.busy     = 1'b1;
                            next_r.state    = CSTX_TBL_WAIT;
                        end
                        CSTX_TBL_LAST: begin
                            next_r.rom_re   = 1'b1;
                            next_r.rom_addr = {`CSTX_LAST_PAGE,
                                               REQ.ptr};
                            next_r.busy     = 1'b1;
                            next_r.state    = CSTX_TBL_WAIT;
                        end
                        CSTX_XOR_ACC, CSTX_XOR_IMM: begin
                            next_r.acc       = xor_y;
                            next_r.zero_flag = xor_z;
                            next_r.done      = 1'b1;
                        end
                        CSTX_XOR_MEM: begin
                            next_r.mem_we    = 1'b1;
                            next_r.mem_wdata = xor_y;
                            next_r.zero_flag = xor_z;
                            next_r.done      = 1'b1;
                        end
                        default: begin
                            next_r.done = 1'b1;
                        end
                    endcase
                end
            end
            CSTX_TBL_WAIT: begin
                // program memory answers in the same cycle as the read strobe
                next_r.mem_we    = 1'b1;
                next_r.mem_wdata = ROM_DATA[`CSTX_WORD_LO];
                next_r.tbl_high  = ROM_DATA[`CSTX_WORD_HI];
                next_r.busy      = 1'b0;
                next_r.done      = 1'b1;
                next_r.state     = CSTX_IDLE;
            end
            CSTX_DUMMY: begin
                // dummy cycle replaces the discarded prefetch
                next_r.busy  = 1'b0;
                next_r.done  = 1'b1;
                next_r.state = CSTX_IDLE;
            end
            default: begin
                next_r.state = CSTX_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            r           <= '0;
            r.state     <= CSTX_IDLE;
            r.acc       <= `CSTX_ACC_RST;
            r.tbl_high  <= `CSTX_TABLE_HIGH_LATCH_RST;
        end else begin
            r <= next_r;
        end
    end

    assign ROM_RE    = r.rom_re;
    assign ROM_ADDR  = r.rom_addr;
    assign MEM_WE    = r.mem_we;
    assign MEM_WDATA = r.mem_wdata;
    assign ACC       = r.acc;
    assign TBL_HIGH  = r.tbl_high;
    assign ZERO_FLAG = r.zero_flag;
    assign SKIP      = r.skip;
    assign BUSY      = r.busy;
    assign DONE      = r.done;

    sequence s_skip_req;
        REQ.valid && !BUSY && (REQ.op == CSTX_SKIP_ZERO) && byte_zero;
    endsequence
    sequence s_two_cycles;
        SKIP && BUSY ##1 DONE && !BUSY;
    endsequence

    a_skip_two_cycles: assert property (
        s_skip_req |=> s_two_cycles)
        else $error("zero skip not two cycles");
    a_noskip_one_cycle: assert property (
        REQ.valid && !BUSY && REQ.op == CSTX_SKIP_ZERO && !byte_zero
        |=> DONE && !SKIP)
        else $error("nonzero skip not one cycle");
    a_swap_nibbles: assert property (
        REQ.valid && !BUSY && REQ.op == CSTX_SWAP_ACC
        |=> ACC == {$past(REQ.mem_data[`CSTX_NIB_LO]),
                    $past(REQ.mem_data[`CSTX_NIB_HI])}
            && $stable(ZERO_FLAG) && !MEM_WE)
        else $error("nibble swap wrong");
    a_copy_skip: assert property (
        REQ.valid && !BUSY && REQ.op == CSTX_COPY_SKIP
        |=> ACC == $past(REQ.mem_data)
            && SKIP == ($past(REQ.mem_data) == `CSTX_ZERO_BYTE))
        else $error("copy skip wrong");
    a_copy_two_cycles: assert property (
        REQ.valid && !BUSY && REQ.op == CSTX_COPY_SKIP
        && REQ.mem_data == `CSTX_ZERO_BYTE |=> s_two_cycles)
        else $error("zero copy skip not two cycles");
    a_bit_skip: assert property (
        REQ.valid && !BUSY && REQ.op == CSTX_BIT_SKIP
        |=> SKIP != $past(REQ.mem_data[REQ.bit_sel]))
        else $error("bit skip wrong");
    a_bit_two_cycles: assert property (
        REQ.valid && !BUSY && REQ.op == CSTX_BIT_SKIP
        && !REQ.mem_data[REQ.bit_sel] |=> s_two_cycles)
        else $error("clear bit skip not two cycles");
    a_tbl_cur_addr: assert property (
        REQ.valid && !BUSY && REQ.op == CSTX_TBL_CUR
        |=> ROM_RE && ROM_ADDR == {$past(REQ.pc[`CSTX_PC_PAGE]),
                                   $past(REQ.ptr)})
        else $error("current page address wrong");
    a_tbl_last_addr: assert property (
        REQ.valid && !BUSY && REQ.op == CSTX_TBL_LAST
        |=> ROM_RE && ROM_ADDR == {`CSTX_LAST_PAGE, $past(REQ.ptr)})
        else $error("last page wrong");
    a_tbl_write: assert property (
        ROM_RE |=> MEM_WE && DONE
            && MEM_WDATA == $past(ROM_DATA[`CSTX_WORD_LO])
            && TBL_HIGH == $past(ROM_DATA[`CSTX_WORD_HI]))
        else $error("table data wrong");
    a_xor_acc: assert property (
        REQ.valid && !BUSY && REQ.op == CSTX_XOR_ACC
        |=> ACC == ($past(ACC) ^ $past(REQ.mem_data))
            && ZERO_FLAG == (ACC == `CSTX_ZERO_BYTE))
        else $error("xor acc wrong");
    a_xor_mem: assert property (
        REQ.valid && !BUSY && REQ.op == CSTX_XOR_MEM
        |=> MEM_WE && MEM_WDATA == ($past(ACC) ^ $past(REQ.mem_data))
            && $stable(ACC)
            && ZERO_FLAG == (MEM_WDATA == `CSTX_ZERO_BYTE))
        else $error("xor mem wrong");
    a_xor_imm: assert property (
        REQ.valid && !BUSY && REQ.op == CSTX_XOR_IMM
        |=> ACC == ($past(ACC) ^ $past(REQ.imm))
            && ZERO_FLAG == (ACC == `CSTX_ZERO_BYTE))
        else $error("xor imm wrong");
endmodule : cstx_exec

// File: testbench/cstx_exec_tb_top.sv
// self-checking bench for the swap, skip, table-read and xor unit
`timescale 1ns/10ps
`include "cstx_defs.svh"
module cstx_exec_tb_top
    import cstx_pkg::*;
;
    logic        clk_sys;
    logic        reset;
    cstx_req_t   req;
    logic [15:0] rom_data = 16'h0000;
    logic        rom_re;
    logic [13:0] rom_addr;
    logic        mem_we;
    logic [7:0]  mem_wdata;
    logic [7:0]  acc;
    logic [7:0]  tbl_high;
    logic        zero_flag;
    logic        skip;
    logic        busy;
    logic        done;
    int          failures;
    int          comparisons;

    cstx_exec u_dut (
        .CLK_SYS   (clk_sys),
        .RESET     (reset),
        .REQ       (req),
        .ROM_DATA  (rom_data),
        .ROM_RE    (rom_re),
        .ROM_ADDR  (rom_addr),
        .MEM_WE    (mem_we),
        .MEM_WDATA (mem_wdata),
        .ACC       (acc),
        .TBL_HIGH  (tbl_high),
        .ZERO_FLAG (zero_flag),
        .SKIP      (skip),
        .BUSY      (busy),
        .DONE      (done)
    );

    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;

    function automatic logic [15:0] word_at(input logic [13:0] a);
        return {a[7:0] ^ 8'ha5, 2'h0, a[13:8]};
    endfunction : word_at

    // program memory answers only in the cycle in which the read strobe is high;
    // otherwise it toggles so a late sample cannot pass by luck
    always @(posedge clk_sys) begin
        #1;
        rom_data = rom_re ? word_at(rom_addr) : ~rom_data;
    end

    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk

    // drive one request for one cycle, return just after the answer edge
    task automatic issue(input cstx_op_t op, input logic [7:0] mem,
                         input logic [7:0] imm, input logic [2:0] bs,
                         input logic [13:0] pc, input logic [7:0] ptr);
        @(posedge clk_sys);
        #1;
        req = '{valid:1'b1, op:op, bit_sel:bs, imm:imm, mem_data:mem,
                pc:pc, ptr:ptr};
        @(posedge clk_sys);
        #1;
        req.valid = 1'b0;
    endtask : issue

    task automatic xor_step(input cstx_op_t op, input logic [7:0] v,
                            input logic [7:0] ea, input logic ewe,
                            input logic [7:0] ewd, input logic ez);
        issue(op, v, v, 3'h0, 14'h0000, 8'h00);
        chk(done === 1'b1 && acc === ea && mem_we === ewe, "xor/swap acc");
        chk(zero_flag === ez && skip === 1'b0, "xor/swap flag");
        if (ewe === 1'b1) begin
            chk(mem_wdata === ewd, "xor write-back data");
        end
    endtask : xor_step

    task automatic t_reset;
        chk({mem_we, rom_re, skip, busy, done, zero_flag} === 6'h00 &&
            acc === 8'h00 && tbl_high === 8'h00, "reset outputs");
        $display("test reset done");
    endtask : t_reset

    task automatic t_xor_swap;
        xor_step(CSTX_XOR_IMM, 8'hc3, 8'hc3, 1'b0, 8'h00, 1'b0);
        xor_step(CSTX_SWAP_ACC, 8'h5a, 8'ha5, 1'b0, 8'h00, 1'b0);
        xor_step(CSTX_XOR_IMM, 8'ha5, 8'h00, 1'b0, 8'h00, 1'b1);
        xor_step(CSTX_SWAP_ACC, 8'h21, 8'h12, 1'b0, 8'h00, 1'b1);
        xor_step(CSTX_XOR_ACC, 8'h13, 8'h01, 1'b0, 8'h00, 1'b0);
        xor_step(CSTX_XOR_MEM, 8'h01, 8'h01, 1'b1, 8'h00, 1'b1);
        xor_step(CSTX_XOR_MEM, 8'hf0, 8'h01, 1'b1, 8'hf1, 1'b0);
        // the no-operation op only finishes, leaving every result alone
        xor_step(CSTX_NOP, 8'hff, 8'h01, 1'b0, 8'h00, 1'b0);
        $display("test xor and swap done");
    endtask : t_xor_swap

    task automatic t_skips;
        cstx_op_t   ops [8] = '{CSTX_SKIP_ZERO, CSTX_SKIP_ZERO,
                                CSTX_COPY_SKIP, CSTX_COPY_SKIP,
                                CSTX_BIT_SKIP, CSTX_BIT_SKIP,
                                CSTX_BIT_SKIP, CSTX_BIT_SKIP};
        logic [7:0] mems[8] = '{8'h00, 8'h01, 8'h00, 8'h80,
                                8'h7f, 8'hfe, 8'h01, 8'h80};
        logic [2:0] bss [8] = '{3'h0, 3'h0, 3'h0, 3'h0,
                                3'h7, 3'h0, 3'h0, 3'h7};
        logic       sk  [8] = '{1'b1, 1'b0, 1'b1, 1'b0,
                                1'b1, 1'b1, 1'b0, 1'b0};
        logic [7:0] a0;
        logic       zf;
        for (int i = 0; i < 8; i++) begin
            a0 = acc;
            zf = zero_flag;
            issue(ops[i], mems[i], 8'h00, bss[i], 14'h0000, 8'h00);
            chk(skip === sk[i] && busy === sk[i],
                "skip decision");
            chk(done === ~sk[i],
                "first-cycle completion");
            if (sk[i] === 1'b1) begin
                @(posedge clk_sys);
                #1;
                chk(done === 1'b1 && busy === 1'b0 && skip === 1'b0,
                    "dummy cycle end");
            end
            chk(acc === ((ops[i] == CSTX_COPY_SKIP) ? mems[i] : a0),
                "copy into accumulator");
            chk(zero_flag === zf && mem_we === 1'b0,
                "skip side effects");
        end
        $display("test skips done");
    endtask : t_skips

    task automatic t_table;
        logic [13:0] ea;
        logic [15:0] w;
        logic [7:0]  a0;
        cstx_op_t    op;
        for (int k = 0; k < 2; k++) begin
            op = (k == 0) ? CSTX_TBL_CUR : CSTX_TBL_LAST;
            ea = (k == 0) ? 14'h2a3b : {`CSTX_LAST_PAGE, 8'hc4};
            a0 = acc;
            issue(op, 8'h00, 8'h00, 3'h0, {6'h2a, 8'h17}, ea[7:0]);
            chk(rom_re === 1'b1 && rom_addr === ea && busy === 1'b1,
                "table address");
            chk(done === 1'b0 && mem_we === 1'b0,
                "table early finish");
            @(posedge clk_sys);
            #1;
            w = word_at(ea);
            chk(mem_we === 1'b1 && mem_wdata === w[7:0] && done === 1'b1,
                "table low byte");
            chk(tbl_high === w[15:8] && acc === a0,
                "table high byte");
        end
        $display("test table reads done");
    endtask : t_table

    task automatic complete_run;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // the whole run needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge clk_sys);
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        reset = 1'b1;
        req = '0;
        failures = 0;
        comparisons = 0;
        repeat (12) @(posedge clk_sys);
        #1;
        t_reset();
        reset = 1'b0;
        t_xor_swap();
        t_skips();
        t_table();
        complete_run();
    end
endmodule : cstx_exec_tb_top
